// file: logic/mpra_ctrl.sv
// Controller that drives the multipurpose store access mode
`timescale 1ns/100ps
`include "mpra_consts.svh"
module mpra_ctrl
(
   // Clock and reset
   input  wire logic                clock,
   input  wire logic                resetn,
   // User orders
   input  wire logic                req_valid,
   output logic                     req_ready,
   input  wire mpra_pkg::mpra_req_s req,
   // User answers
   output logic                     rsp_valid,
   output logic [7:0]               rsp_data,
   output logic                     mode_active,
   // Device command bus
   output mpra_pkg::mpra_cmd_s      cmd,
   output logic                     dbi_n,
   output logic                     cke,
   output logic                     reset_n_dev,
   // Device data lane 0
   input  wire logic                dq_in,
   output logic                     dq_out,
   output logic                     dq_oe
);
   // ****************************************
   // Reset release
   // ****************************************
   logic rs1_r;
   logic rst_n;

   // Two stage release of the reset
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         rs1_r <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rs1_r <= 1'b1;
         rst_n <= rs1_r;
      end
   end

   // ****************************************
   // State and registers
   // ****************************************
   typedef enum logic [5:0]
   {
      ST_IDLE  = 6'b000001,
      ST_ISSUE = 6'b000010,
      ST_LAT   = 6'b000100,
      ST_BEAT  = 6'b001000,
      ST_HOLD  = 6'b010000,
      ST_DONE  = 6'b100000
   } mpra_st_e;

   mpra_st_e            st_r, st_nxt;
   mpra_pkg::mpra_req_s q_r, q_nxt;
   mpra_pkg::mpra_cmd_s cmd_r, cmd_nxt;
   logic                act_r, act_nxt;
   logic [1:0]          page_r, page_nxt;
   logic [7:0]          shf_r, shf_nxt;
   logic [3:0]          beat_r, beat_nxt;
   logic [7:0]          lat_r, lat_nxt;
   logic                vld_r, vld_nxt;
   logic                dqo_r, dqo_nxt;
   logic                dqe_r, dqe_nxt;
   logic                wload;
   logic [7:0]          wcount;
   logic                wbusy;

   // Guard timer; holds off the next order after each command except a read
   mpra_wait u_wait
   (
      .clock (clock),
      .rst_n (rst_n),
      .load  (wload),
      .count (wcount),
      .busy  (wbusy)
   );

   // Idle command: deselect keeps the bus quiet between orders
   function automatic mpra_pkg::mpra_cmd_s cmd_des();
      mpra_pkg::mpra_cmd_s c;
      c       = '0;
      c.cs_n  = 1'b1;
      c.act_n = 1'b1;
      c.ras_n = 1'b1;
      c.cas_n = 1'b1;
      c.we_n  = 1'b1;
      return c;
   endfunction : cmd_des

   // Build one of the allowed command codes
   function automatic mpra_pkg::mpra_cmd_s cmd_mk(input logic ras,
      input logic cas, input logic we);
      mpra_pkg::mpra_cmd_s c;
      c       = cmd_des();
      c.cs_n  = 1'b0;
      c.ras_n = ras;
      c.cas_n = cas;
      c.we_n  = we;
      return c;
   endfunction : cmd_mk

   // Held low until the reset copy releases, so no order is lost
   assign req_ready = rst_n && (st_r == ST_IDLE) && !wbusy;

   // Next state, command and data
   always_comb
   begin
      st_nxt   = st_r;
      q_nxt    = q_r;
      cmd_nxt  = cmd_des();
      act_nxt  = act_r;
      page_nxt = page_r;
      shf_nxt  = shf_r;
      beat_nxt = beat_r;
      lat_nxt  = lat_r;
      vld_nxt  = 1'b0;
      dqo_nxt  = dqo_r;
      dqe_nxt  = 1'b0;
      wload    = 1'b0;
      wcount   = 8'h00;
      case (st_r)
         ST_IDLE:
         begin
            if (req_valid && req_ready)
            begin
               q_nxt  = req;
               st_nxt = ST_ISSUE;
            end
         end
         ST_ISSUE:
         begin
            st_nxt = ST_DONE;
            case (q_r.op)
               mpra_pkg::MPRA_OP_ENTER:
               begin
                  // Caller keeps banks precharged before entry
                  cmd_nxt = cmd_mk(1'b0, 1'b0, 1'b0);
                  cmd_nxt.bg = 2'h0;
                  cmd_nxt.ba = 2'(`MPRA_MR3_INDEX);
                  cmd_nxt.addr = `MPRA_MR3_BASE;
                  cmd_nxt.addr[`MPRA_MR3_EN_BIT] = 1'b1;
                  cmd_nxt.addr[1:0] = q_r.page;
                  act_nxt  = 1'b1;
                  page_nxt = q_r.page;
                  wload  = 1'b1;
                  wcount = 8'(`MPRA_TMOD_CYC);
               end
               mpra_pkg::MPRA_OP_EXIT:
               begin
                  cmd_nxt = cmd_mk(1'b0, 1'b0, 1'b0);
                  cmd_nxt.ba = 2'(`MPRA_MR3_INDEX);
                  cmd_nxt.addr = `MPRA_MR3_BASE;
                  act_nxt = 1'b0;
                  wload  = 1'b1;
                  wcount = 8'(`MPRA_TMOD_CYC);
               end
               mpra_pkg::MPRA_OP_REF:
               begin
                  // Only reached from idle, so access is finished
                  cmd_nxt = cmd_mk(1'b0, 1'b0, 1'b1);
                  wload  = 1'b1;
                  wcount = 8'(`MPRA_TRFC_CYC);
               end
               mpra_pkg::MPRA_OP_READ:
               begin
                  if (act_r)
                  begin
                     cmd_nxt = cmd_mk(1'b1, 1'b0, 1'b1);
                     cmd_nxt.ba = q_r.loc;
                     // Fixed burst, low bits 000 or 100
                     cmd_nxt.addr[2:0] = q_r.chop ? `MPRA_BC4_HIGH
                                                  : `MPRA_BC4_LOW;
                     cmd_nxt.addr[12] = 1'b1;
                     lat_nxt  = 8'(`MPRA_RL_CYC);
                     beat_nxt = 4'h0;
                     st_nxt   = ST_LAT;
                  end
               end
               default:
               begin
                  // Only page 0 takes writes
                  if (act_r && page_r == 2'h0)
                  begin
                     cmd_nxt = cmd_mk(1'b1, 1'b0, 1'b0);
                     cmd_nxt.ba = q_r.loc;
                     cmd_nxt.addr[7:0] = q_r.wdata;
                     cmd_nxt.addr[12] = 1'b1;
                     wload  = 1'b1;
                     wcount = 8'(`MPRA_WL_CYC);
                  end
               end
            endcase
         end
         ST_LAT:
         begin
            if (lat_r == 8'h01)
            begin
               st_nxt = ST_BEAT;
            end
            lat_nxt = lat_r - 8'h01;
         end
         ST_BEAT:
         begin
            // Serial beats, UI0 lands in bit 7
            shf_nxt  = {shf_r[6:0], dq_in};
            beat_nxt = beat_r + 4'h1;
            if (beat_r == (q_r.chop ? `MPRA_BC_BEATS : `MPRA_BL_BEATS)
                          - 4'h1)
            begin
               st_nxt = ST_HOLD;
            end
         end
         ST_HOLD:
         begin
            // Burst chop fills only the top nibble
            if (q_r.chop)
            begin
               shf_nxt = {shf_r[3:0], 4'h0};
            end
            vld_nxt = 1'b1;
            st_nxt  = ST_IDLE;
         end
         default:
         begin
            st_nxt = ST_IDLE;
         end
      endcase
   end

   // Register all state
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r   <= ST_IDLE;
         q_r    <= '0;
         cmd_r  <= cmd_des();
         act_r  <= 1'b0;
         page_r <= 2'h0;
         shf_r  <= 8'h00;
         beat_r <= 4'h0;
         lat_r  <= 8'h00;
         vld_r  <= 1'b0;
         dqo_r  <= 1'b0;
         dqe_r  <= 1'b0;
      end
      else
      begin
         st_r   <= st_nxt;
         q_r    <= q_nxt;
         cmd_r  <= cmd_nxt;
         act_r  <= act_nxt;
         page_r <= page_nxt;
         shf_r  <= shf_nxt;
         beat_r <= beat_nxt;
         lat_r  <= lat_nxt;
         vld_r  <= vld_nxt;
         dqo_r  <= dqo_nxt;
         dqe_r  <= dqe_nxt;
      end
   end

   // Outputs; power down never taken and DBI held off
   assign cmd         = cmd_r;
   assign dbi_n       = 1'b1;
   assign cke         = 1'b1;
   assign reset_n_dev = rst_n;
   assign dq_out      = dqo_r;
   assign dq_oe       = dqe_r;
   assign rsp_valid   = vld_r;
   assign rsp_data    = shf_r;
   assign mode_active = act_r;
endmodule : mpra_ctrl

// file: logic/mpra_wait.sv
// Down counter that holds off the next command
`timescale 1ns/100ps
module mpra_wait
(
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst_n,
   // Load and status
   input  wire logic       load,
   input  wire logic [7:0] count,
   output logic            busy
);
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;

   // Next count
   always_comb
   begin
      cnt_nxt = cnt_r;
      if (load)
      begin
         cnt_nxt = count;
      end
      else if (cnt_r != 8'h00)
      begin
         cnt_nxt = cnt_r - 8'h01;
      end
   end

   // Register
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_r <= 8'h00;
      end
      else
      begin
         cnt_r <= cnt_nxt;
      end
   end

   assign busy = (cnt_r != 8'h00);
endmodule : mpra_wait

// file: shared/mpra_consts.svh
// Constants for the multipurpose store access controller
`ifndef MPRA_CONSTS_SVH
`define MPRA_CONSTS_SVH
// ****************************************
// Mode register three fields
// ****************************************
`define MPRA_MR3_INDEX    3'h3
`define MPRA_MR3_EN_BIT   2
`define MPRA_MR3_PAGE_LSB 0
`define MPRA_MR3_BASE     18'h00000
// ****************************************
// Burst and data constants
// ****************************************
`define MPRA_BL_BEATS     4'h8
`define MPRA_BC_BEATS     4'h4
`define MPRA_BC4_LOW      3'h0
`define MPRA_BC4_HIGH     3'h4
// ****************************************
// Timing, at 100 MHz
// ****************************************
`define MPRA_CLK_NS       10
`define MPRA_TRFC_NS      350
`define MPRA_TRFC_CYC     ((`MPRA_TRFC_NS + `MPRA_CLK_NS - 1) / `MPRA_CLK_NS)
`define MPRA_TRP_NS       15
`define MPRA_TRP_CYC      ((`MPRA_TRP_NS + `MPRA_CLK_NS - 1) / `MPRA_CLK_NS)
`define MPRA_TMOD_CYC     24
`define MPRA_RL_CYC       20
`define MPRA_WL_CYC       16
`endif

// file: shared/mpra_pkg.sv
// Types for the multipurpose store access controller
package mpra_pkg;
   // User order codes
   typedef enum logic [2:0]
   {
      MPRA_OP_ENTER = 3'h0,
      MPRA_OP_EXIT  = 3'h1,
      MPRA_OP_READ  = 3'h2,
      MPRA_OP_WRITE = 3'h3,
      MPRA_OP_REF   = 3'h4
   } mpra_op_e;
   // One order from the user side
   typedef struct packed
   {
      mpra_op_e    op;
      logic [1:0]  page;
      logic [1:0]  loc;
      logic        chop;
      logic [7:0]  wdata;
   } mpra_req_s;
   // Command bus towards the device
   typedef struct packed
   {
      logic        cs_n;
      logic        act_n;
      logic        ras_n;
      logic        cas_n;
      logic        we_n;
      logic [1:0]  bg;
      logic [1:0]  ba;
      logic [17:0] addr;
   } mpra_cmd_s;
endpackage : mpra_pkg

// file: tb/mpra_ctrl_properties.sv
// Port checker for the multipurpose store access controller
`timescale 1ns/100ps
module mpra_ctrl_properties
(
   // Clock and reset
   input wire logic                clock,
   input wire logic                resetn,
   // User side
   input wire logic                req_valid,
   input wire logic                req_ready,
   input wire mpra_pkg::mpra_req_s req,
   input wire logic                mode_active,
   // Device side
   input wire mpra_pkg::mpra_cmd_s cmd,
   input wire logic                dbi_n,
   input wire logic                cke,
   input wire logic                dq_oe
);
   // ***
   // Decode
   // ***
   logic [5:0] quiet_r;
   logic [5:0] quiet_nxt;
   logic [1:0] sel_r;
   logic [1:0] sel_nxt;
   wire tk = req_valid && req_ready;
   wire cs = !cmd.cs_n && cmd.act_n;
   wire rd = cs && cmd.ras_n && !cmd.cas_n && cmd.we_n;
   wire wr = cs && cmd.ras_n && !cmd.cas_n && !cmd.we_n;
   wire rf = cs && !cmd.ras_n && !cmd.cas_n && cmd.we_n;
   wire ms = cs && !cmd.ras_n && !cmd.cas_n && !cmd.we_n;
   wire tk_rd = tk && req.op == mpra_pkg::MPRA_OP_READ;
   wire tk_en = tk && req.op == mpra_pkg::MPRA_OP_ENTER;
   wire tk_wr = tk && req.op == mpra_pkg::MPRA_OP_WRITE;
   // Cycles since refresh, one short of the guard; page seen on the bus
   always_comb
   begin
      quiet_nxt = rf ? 6'h01 : 6'h00;
      if (!rf && quiet_r != 6'h00 && quiet_r < 6'h22)
         quiet_nxt = quiet_r + 6'h01;
      sel_nxt = sel_r;
      if (ms && cmd.ba == 2'h3)
         sel_nxt = cmd.addr[1:0];
   end
   // Counter and page registers
   always_ff @(posedge clock or negedge resetn)
      if (!resetn)
      begin
         quiet_r <= 6'h00;
         sel_r   <= 2'h0;
      end
      else
      begin
         quiet_r <= quiet_nxt;
         sel_r   <= sel_nxt;
      end
   // ***
   // Properties
   // ***
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   dbi_off_a: assert property (dbi_n)
      else $error("inversion enabled");
   cke_on_a: assert property (cke)
      else $error("clock enable dropped");
   read_issue_a: assert property (tk_rd && mode_active
      |-> ##2 rd && cmd.ba == $past(req.loc, 2))
      else $error("read not issued to location");
   read_refuse_a: assert property (tk_rd && !mode_active
      |-> ##2 cmd.cs_n [*3])
      else $error("read issued outside mode");
   burst_fixed_a: assert property (rd |-> cmd.addr[1:0] == 2'h0)
      else $error("bad burst address");
   no_autopre_a: assert property (rd || wr |-> !cmd.addr[10])
      else $error("auto precharge set");
   cmd_legal_a: assert property (!cmd.cs_n && mode_active
      |-> cmd.act_n && (rd || wr || rf || ms))
      else $error("forbidden command in mode");
   refresh_quiet_a: assert property (quiet_r != 6'h00 |-> cmd.cs_n)
      else $error("command inside refresh time");
   enter_mrs_a: assert property (tk_en
      |-> ##2 ms && cmd.ba == 2'h3
      && cmd.addr[2:0] == {1'b1, $past(req.page, 2)})
      else $error("bad mode entry command");
   write_addr_a: assert property (tk_wr
      |-> ##2 cmd.cs_n || wr && cmd.addr[7:0] == $past(req.wdata, 2))
      else $error("write data not on address");
   write_page_a: assert property (wr |-> sel_r == 2'h0)
      else $error("write outside page zero");
   lane_idle_a: assert property (!dq_oe)
      else $error("data lane driven");
endmodule : mpra_ctrl_properties
bind mpra_ctrl mpra_ctrl_properties u_props
(
   .clock(clock), .resetn(resetn), .req_valid(req_valid),
   .req_ready(req_ready), .req(req), .mode_active(mode_active),
   .cmd(cmd), .dbi_n(dbi_n), .cke(cke), .dq_oe(dq_oe)
);

// file: tb/mpra_dev_model.sv
// Behavioural device answering store reads and writes
`timescale 1ns/100ps
`include "mpra_consts.svh"
module mpra_dev_model
(
   // Clock and device reset
   input  wire logic                clock,
   input  wire logic                rst_n,
   // Command in, data lane out
   input  wire mpra_pkg::mpra_cmd_s cmd,
   output logic                     dq
);
   localparam int RL = `MPRA_RL_CYC;
   logic [7:0] st [4];
   logic       on;
   logic [1:0] pg;
   logic [7:0] sh;
   logic [5:0] t;
   wire c  = !cmd.cs_n && cmd.act_n;
   wire rd = c && cmd.ras_n && !cmd.cas_n && cmd.we_n;
   wire wr = c && cmd.ras_n && !cmd.cas_n && !cmd.we_n;
   wire ms = c && !cmd.ras_n && !cmd.cas_n && !cmd.we_n;
   // Store, mode and burst; lane toggles when not driven
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
      begin
         st <= '{8'h55, 8'h33, 8'h0F, 8'h00};
         on <= 1'b0;
         pg <= 2'h0;
         sh <= 8'h00;
         t  <= 6'h00;
         dq <= 1'b0;
      end
      else
      begin
         if (ms && cmd.ba == 2'h3)
         begin
            on <= cmd.addr[2];
            pg <= cmd.addr[1:0];
         end
         if (wr && on && pg == 2'h0)
            st[cmd.ba] <= cmd.addr[7:0];
         if (rd && on)
         begin
            // Other pages: arbitrary serial bytes
            sh <= pg != 2'h0 ? {pg, cmd.ba, 4'h9} : st[cmd.ba];
            t  <= 6'h01;
         end
         else
            t <= t != 6'h00 && t < 6'h28 ? t + 6'h01 : 6'h00;
         if (t >= RL - 1 && t < RL + 7)
            dq <= sh[RL + 6 - t];
         else
            dq <= ~dq;
      end
endmodule : mpra_dev_model

// file: tb/tb.sv
// Testbench for the multipurpose store access controller
`timescale 1ns/100ps
module tb;
   logic                clock;
   logic                resetn;
   logic                req_valid;
   logic                req_ready;
   mpra_pkg::mpra_req_s req;
   logic                rsp_valid;
   logic [7:0]          rsp_data;
   logic                mode_active;
   mpra_pkg::mpra_cmd_s cmd;
   logic                dq;
   logic                rst_dev;
   int                  errors;
   int                  checks_done;
   int                  nx;
   mpra_ctrl dut
   (
      .clock(clock), .resetn(resetn), .req_valid(req_valid),
      .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .mode_active(mode_active), .cmd(cmd),
      .dbi_n(), .cke(), .reset_n_dev(rst_dev), .dq_in(dq),
      .dq_out(), .dq_oe()
   );
   mpra_dev_model dev (.clock(clock), .rst_n(rst_dev), .cmd(cmd), .dq(dq));
   // ***
   // Tasks
   // ***
   task automatic conclude;
      $display("errors %0d checks_done %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : conclude
   task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e)
      begin
         errors++;
         $display("FAIL %0t got %h want %h", $time, g, e);
      end
   endtask : cmp8
   // One order, held until taken
   task automatic go(input mpra_pkg::mpra_op_e op, input logic [1:0] pg,
                     input logic [1:0] lc, input logic ch,
                     input logic [7:0] wd);
      int n;
      n = 0;
      @(negedge clock);
      while (req_ready !== 1'b1 && n < 300)
      begin
         @(negedge clock);
         n++;
      end
      req = '{op, pg, lc, ch, wd};
      req_valid = 1'b1;
      @(posedge clock);
      @(negedge clock);
      req_valid = 1'b0;
   endtask : go
   task automatic rd(input logic [1:0] lc, input logic ch,
                     input logic [7:0] e);
      int n;
      n = 0;
      go(mpra_pkg::MPRA_OP_READ, 2'h0, lc, ch, 8'h00);
      while (rsp_valid !== 1'b1 && n < 100)
      begin
         @(negedge clock);
         n++;
      end
      // A missing answer must not pass on stale data
      cmp8({7'h00, rsp_valid}, 8'h01);
      cmp8(rsp_data, e);
   endtask : rd
   // ***
   // Clock, watchdog, sequence
   // ***
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Tests need well under 5000 cycles
   initial
   begin
      repeat (20000) @(posedge clock);
      errors++;
      conclude();
   end
   initial
   begin
      errors = 0;
      checks_done = 0;
      resetn = 1'b0;
      req_valid = 1'b0;
      req = '0;
      repeat (12) @(posedge clock);
      @(negedge clock);
      resetn = 1'b1;
      go(mpra_pkg::MPRA_OP_READ, 2'h0, 2'h0, 1'b0, 8'h00);
      nx = 0;
      repeat (40)
      begin
         @(negedge clock);
         nx += rsp_valid;
      end
      cmp8(nx[7:0], 8'h00);
      go(mpra_pkg::MPRA_OP_ENTER, 2'h0, 2'h0, 1'b0, 8'h00);
      repeat (30) @(negedge clock);
      cmp8({7'h00, mode_active}, 8'h01);
      rd(2'h0, 1'b0, 8'h55);
      rd(2'h1, 1'b0, 8'h33);
      rd(2'h2, 1'b0, 8'h0F);
      rd(2'h3, 1'b0, 8'h00);
      rd(2'h0, 1'b1, 8'h50);
      go(mpra_pkg::MPRA_OP_WRITE, 2'h0, 2'h1, 1'b0, 8'hA5);
      rd(2'h1, 1'b0, 8'hA5);
      go(mpra_pkg::MPRA_OP_REF, 2'h0, 2'h0, 1'b0, 8'h00);
      rd(2'h2, 1'b0, 8'h0F);
      // Other pages read only; writes there must not land
      for (int p = 1; p < 4; p++)
      begin
         go(mpra_pkg::MPRA_OP_ENTER, p[1:0], 2'h0, 1'b0, 8'h00);
         rd(2'h2, 1'b0, {p[1:0], 2'h2, 4'h9});
         go(mpra_pkg::MPRA_OP_WRITE, p[1:0], 2'h0, 1'b0, 8'h3C);
      end
      go(mpra_pkg::MPRA_OP_ENTER, 2'h0, 2'h0, 1'b0, 8'h00);
      rd(2'h0, 1'b0, 8'h55);
      go(mpra_pkg::MPRA_OP_EXIT, 2'h0, 2'h0, 1'b0, 8'h00);
      repeat (30) @(negedge clock);
      cmp8({7'h00, mode_active}, 8'h00);
      go(mpra_pkg::MPRA_OP_ENTER, 2'h0, 2'h0, 1'b0, 8'h00);
      repeat (30) @(negedge clock);
      resetn = 1'b0;
      repeat (3) @(negedge clock);
      cmp8({7'h00, mode_active}, 8'h00);
      resetn = 1'b1;
      go(mpra_pkg::MPRA_OP_ENTER, 2'h0, 2'h0, 1'b0, 8'h00);
      rd(2'h1, 1'b0, 8'h33);
      conclude();
   end
endmodule : tb
